// >>> rtl/lps_pkg.sv
package lps_pkg;
	// command codes and cdb byte positions
	localparam logic [7:0] LPS_OP_SELECT = 8'h4c;
	localparam logic [7:0] LPS_OP_SENSE = 8'h4d;
	localparam int LPS_B_OP = 0;
	localparam int LPS_B_FLAGS = 1;
	localparam int LPS_B_PAGE = 2;
	localparam int LPS_B_SUB = 3;
	localparam int LPS_B_PTR_HI = 5;
	localparam int LPS_B_PTR_LO = 6;
	localparam int LPS_B_LEN_HI = 7;
	localparam int LPS_B_LEN_LO = 8;
	localparam int LPS_BIT_SAVE = 0;
	localparam int LPS_BIT_RESET = 1;
	localparam int LPS_BIT_POINTER = 1;
	localparam int LPS_PC_LSB = 6;
	localparam int LPS_PAGE_W = 6;
	// page control and format-and-linking codes
	localparam logic [1:0] LPS_PC_CUR = 2'h1;
	localparam logic [1:0] LPS_PC_DEF = 2'h3;
	localparam logic [1:0] LPS_FL_ASCII = 2'h1;
	localparam logic [1:0] LPS_FL_BINARY = 2'h3;
	localparam logic [15:0] LPS_MAX_LEN = 16'h00ff;
	localparam logic [15:0] LPS_HDR_LEN = 16'h0004;
	localparam logic [5:0] LPS_PG_START_STOP = 6'h0e;
	localparam logic [5:0] LPS_PG_APP_CLIENT = 6'h0f;
	localparam int LPS_NUM_SUP = 16;
	localparam logic [15:0][5:0] LPS_SUP_PAGES = {6'h37, 6'h30, 6'h2f, 6'h1a, 6'h19, 6'h18,
		6'h15, 6'h10, 6'h0f, 6'h0e, 6'h0d, 6'h06, 6'h05, 6'h03, 6'h02, 6'h00};
	localparam int LPS_NUM_CLR = 8;
	localparam logic [7:0][5:0] LPS_CLR_PAGES = {6'h37, 6'h30, 6'h18, 6'h15,
		6'h06, 6'h05, 6'h03, 6'h02};
	localparam int LPS_NUM_INIT = 8;
	localparam int LPS_IID_W = 3;
	// sense answers
	localparam logic [3:0] LPS_KEY_NONE = 4'h0;
	localparam logic [3:0] LPS_KEY_ILLEGAL = 4'h5;
	localparam logic [7:0] LPS_ASC_NONE = 8'h00;
	localparam logic [7:0] LPS_ASC_CDB = 8'h24;
	localparam logic [7:0] LPS_ASC_PLIST = 8'h26;
	// wishbone register map and fields
	localparam logic [3:0] LPS_REG_STATUS = 4'h0;
	localparam logic [3:0] LPS_REG_UA = 4'h4;
	localparam logic [3:0] LPS_REG_CTRL = 4'h8;
	localparam int LPS_ST_ASC_LSB = 0;
	localparam int LPS_ST_KEY_LSB = 8;
	localparam int LPS_ST_CHK_BIT = 12;
	localparam int LPS_ST_BUSY_BIT = 31;
	localparam logic [3:0] LPS_PORT_RST = 4'h0;

	typedef enum logic [3:0] {
		LPS_ST_IDLE = 4'b0001,
		LPS_ST_RECV = 4'b0010,
		LPS_ST_SEND = 4'b0100,
		LPS_ST_END = 4'b1000
	} lps_st_t;

	typedef enum logic [2:0] {
		LPS_PH_PAGE = 3'b001,
		LPS_PH_PRM = 3'b010,
		LPS_PH_DATA = 3'b100
	} lps_ph_t;

	typedef logic [9:0][7:0] lps_cdb_t;

	typedef struct packed {
		logic [5:0] page;
		logic [15:0] code;
		logic [7:0] data;
	} lps_wr_t;

	typedef struct packed {
		logic check;
		logic [3:0] key;
		logic [7:0] asc;
	} lps_sts_t;
endpackage

// >>> rtl/lps_top.sv
`timescale 1ns/1ps
`default_nettype none

module lps_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// command block
	input wire logic cdb_valid_i,
	input wire lps_pkg::lps_cdb_t cdb_i,
	input wire logic [lps_pkg::LPS_IID_W-1:0] cdb_iid_i,
	output logic cdb_ready_o,
	output logic done_o,
	output lps_pkg::lps_sts_t sts_o,
	// parameter list bytes
	input wire logic dout_valid_i,
	input wire logic [7:0] dout_data_i,
	output logic dout_ready_o,
	// log page source and data-in bytes
	output logic [lps_pkg::LPS_PAGE_W-1:0] log_page_o,
	output logic [1:0] log_pc_o,
	output logic [15:0] param_ptr_o,
	input wire logic src_valid_i,
	input wire logic [7:0] src_data_i,
	input wire logic src_last_i,
	output logic src_ready_o,
	output logic din_valid_o,
	output logic [7:0] din_data_o,
	// log store
	output logic wr_valid_o,
	output lps_pkg::lps_wr_t wr_o,
	output logic save_o,
	output logic clr_valid_o,
	output logic [lps_pkg::LPS_NUM_CLR-1:0] clr_mask_o,
	output logic clr_cur_o,
	output logic clr_def_o,
	output logic [3:0] clr_port_o,
	output logic [lps_pkg::LPS_NUM_INIT-1:0] ua_o,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	typedef struct packed {
		lps_pkg::lps_st_t st;
		lps_pkg::lps_ph_t ph;
		logic [1:0] pos;
		logic sp;
		logic [1:0] pc;
		logic [5:0] page;
		logic [lps_pkg::LPS_IID_W-1:0] iid;
		logic [15:0] len;
		logic [15:0] cnt;
		logic [15:0] ptr;
		logic first;
		logic [5:0] prev_page;
		logic [15:0] exp_code;
		logic [7:0] code_hi;
		logic [1:0] fl;
		logic [15:0] page_rem;
		logic [7:0] prm_rem;
		lps_pkg::lps_sts_t sts;
		logic done;
		logic cdb_rdy;
		logic dout_rdy;
		logic src_rdy;
		logic din_valid;
		logic [7:0] din_data;
		logic wr_valid;
		lps_pkg::lps_wr_t wr;
		logic clr_valid;
		logic [lps_pkg::LPS_NUM_CLR-1:0] clr_mask;
		logic clr_cur;
		logic clr_def;
		logic save;
		logic [lps_pkg::LPS_NUM_INIT-1:0] ua;
		logic [3:0] port;
		logic ack;
		logic [31:0] dat;
	} lps_state_t;

	lps_state_t s_q;
	lps_state_t s_d;
	logic [lps_pkg::LPS_NUM_SUP-1:0] sup_hit;
	logic [lps_pkg::LPS_NUM_CLR-1:0] clr_hit;

	// page lookups against the supported and clearable lists
	genvar gi;
	generate
		for (gi = 0; gi < lps_pkg::LPS_NUM_SUP; gi++)
		begin : g_sup
			assign sup_hit[gi] = cdb_i[lps_pkg::LPS_B_PAGE][5:0] == lps_pkg::LPS_SUP_PAGES[gi];
			if (gi < lps_pkg::LPS_NUM_CLR)
			begin : g_clr
				assign clr_hit[gi] = cdb_i[lps_pkg::LPS_B_PAGE][5:0] == lps_pkg::LPS_CLR_PAGES[gi];
			end
		end
	endgenerate

	always_comb
	begin
		logic [7:0] op;
		logic [1:0] pc;
		logic [5:0] pg;
		logic [15:0] len;
		logic reset_bit;
		logic save_bit;
		logic bad;
		logic err;
		logic [lps_pkg::LPS_NUM_INIT-1:0] others;
		op = cdb_i[lps_pkg::LPS_B_OP];
		pc = cdb_i[lps_pkg::LPS_B_PAGE][lps_pkg::LPS_PC_LSB +: 2];
		pg = cdb_i[lps_pkg::LPS_B_PAGE][5:0];
		len = {cdb_i[lps_pkg::LPS_B_LEN_HI], cdb_i[lps_pkg::LPS_B_LEN_LO]};
		reset_bit = cdb_i[lps_pkg::LPS_B_FLAGS][lps_pkg::LPS_BIT_RESET];
		save_bit = cdb_i[lps_pkg::LPS_B_FLAGS][lps_pkg::LPS_BIT_SAVE];
		bad = 1'b0;
		err = 1'b0;
		others = ~(8'h01 << s_q.iid);
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.din_valid = 1'b0;
		s_d.wr_valid = 1'b0;
		s_d.clr_valid = 1'b0;
		s_d.save = 1'b0;

		// wishbone: one wait state, write lands on the acked edge
		s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
		if (wb_cyc_i && wb_stb_i && !s_q.ack)
		begin
			s_d.dat = 32'h0000_0000;
			if (wb_adr_i == lps_pkg::LPS_REG_STATUS)
			begin
				s_d.dat[lps_pkg::LPS_ST_ASC_LSB +: 8] = s_q.sts.asc;
				s_d.dat[lps_pkg::LPS_ST_KEY_LSB +: 4] = s_q.sts.key;
				s_d.dat[lps_pkg::LPS_ST_CHK_BIT] = s_q.sts.check;
				s_d.dat[lps_pkg::LPS_ST_BUSY_BIT] = s_q.st != lps_pkg::LPS_ST_IDLE;
			end
			else if (wb_adr_i == lps_pkg::LPS_REG_UA)
				s_d.dat[7:0] = s_q.ua;
			else if (wb_adr_i == lps_pkg::LPS_REG_CTRL)
				s_d.dat[3:0] = s_q.port;
		end
		if (wb_cyc_i && wb_stb_i && s_q.ack && wb_we_i && wb_sel_i[0])
		begin
			if (wb_adr_i == lps_pkg::LPS_REG_UA)
				s_d.ua = s_q.ua & ~wb_dat_i[7:0];
			else if (wb_adr_i == lps_pkg::LPS_REG_CTRL)
				s_d.port = wb_dat_i[3:0];
		end

		unique case (s_q.st)
			lps_pkg::LPS_ST_IDLE:
			if (cdb_valid_i && s_q.cdb_rdy && (op == lps_pkg::LPS_OP_SELECT
				|| op == lps_pkg::LPS_OP_SENSE))
			begin
				s_d.cdb_rdy = 1'b0;
				s_d.iid = cdb_iid_i;
				s_d.sp = save_bit;
				s_d.pc = pc;
				s_d.page = pg;
				s_d.len = len;
				s_d.cnt = 16'h0000;
				s_d.sts = '{1'b0, lps_pkg::LPS_KEY_NONE, lps_pkg::LPS_ASC_NONE};
				s_d.st = lps_pkg::LPS_ST_END;
				others = ~(8'h01 << cdb_iid_i);
				if (op == lps_pkg::LPS_OP_SELECT)
				begin
					if (len > lps_pkg::LPS_MAX_LEN)
						bad = 1'b1;
					else if (len != 16'h0000 && reset_bit)
						bad = 1'b1;
					else if (len != 16'h0000 && !save_bit)
						bad = 1'b1;
					else if (len != 16'h0000 && pc == lps_pkg::LPS_PC_DEF)
						bad = 1'b1;
					else if (len != 16'h0000 && (pg != 6'h00
						|| cdb_i[lps_pkg::LPS_B_SUB] != 8'h00))
						bad = 1'b1;
					else if (!(|sup_hit))
						bad = 1'b1;
					if (!bad && len != 16'h0000)
					begin
						s_d.st = lps_pkg::LPS_ST_RECV;
						s_d.dout_rdy = 1'b1;
						s_d.ph = lps_pkg::LPS_PH_PAGE;
						s_d.pos = 2'h0;
						s_d.first = 1'b1;
					end
					else if (!bad)
					begin
						s_d.clr_valid = 1'b1;
						s_d.clr_mask = (pg == 6'h00) ? '1 : clr_hit;
						s_d.clr_cur = reset_bit;
						s_d.clr_def = pc == lps_pkg::LPS_PC_DEF;
						if (reset_bit || pc == lps_pkg::LPS_PC_DEF)
						begin
							s_d.ua = s_d.ua | others;
							s_d.save = save_bit;
						end
					end
				end
				else
				begin
					s_d.ptr = {cdb_i[lps_pkg::LPS_B_PTR_HI], cdb_i[lps_pkg::LPS_B_PTR_LO]};
					if (cdb_i[lps_pkg::LPS_B_FLAGS][lps_pkg::LPS_BIT_POINTER])
						bad = 1'b1;
					else if (pc != lps_pkg::LPS_PC_CUR && pc != lps_pkg::LPS_PC_DEF)
						bad = 1'b1;
					else if (!(|sup_hit))
						bad = 1'b1;
					if (!bad)
					begin
						s_d.save = save_bit;
						if (len != 16'h0000)
						begin
							s_d.st = lps_pkg::LPS_ST_SEND;
							s_d.src_rdy = 1'b1;
						end
					end
				end
				if (bad)
					s_d.sts = '{1'b1, lps_pkg::LPS_KEY_ILLEGAL, lps_pkg::LPS_ASC_CDB};
			end
			lps_pkg::LPS_ST_RECV:
			if (dout_valid_i && s_q.dout_rdy)
			begin
				s_d.cnt = s_q.cnt + 16'h0001;
				s_d.pos = s_q.pos + 2'h1;
				unique case (s_q.ph)
					lps_pkg::LPS_PH_PAGE:
					begin
						if (s_q.pos == 2'h0)
						begin
							err = !s_q.first && dout_data_i[5:0] <= s_q.prev_page;
							s_d.page = dout_data_i[5:0];
						end
						if (s_q.pos == 2'h2)
							s_d.page_rem[15:8] = dout_data_i;
						if (s_q.pos == 2'h3)
						begin
							s_d.page_rem[7:0] = dout_data_i;
							err = s_d.page_rem > s_q.len - s_q.cnt - 16'h0001;
							s_d.first = 1'b0;
							s_d.prev_page = s_q.page;
							s_d.exp_code = 16'h0000;
							if (s_d.page_rem != 16'h0000)
								s_d.ph = lps_pkg::LPS_PH_PRM;
						end
					end
					lps_pkg::LPS_PH_PRM:
					begin
						s_d.page_rem = s_q.page_rem - 16'h0001;
						if (s_q.pos == 2'h0)
						begin
							err = s_q.page_rem < lps_pkg::LPS_HDR_LEN;
							s_d.code_hi = dout_data_i;
						end
						if (s_q.pos == 2'h1)
							err = {s_q.code_hi, dout_data_i} != s_q.exp_code;
						if (s_q.pos == 2'h2)
							s_d.fl = dout_data_i[1:0];
						if (s_q.pos == 2'h3)
						begin
							s_d.prm_rem = dout_data_i;
							err = {8'h00, dout_data_i} > s_d.page_rem;
							if (dout_data_i != 8'h00)
								s_d.ph = lps_pkg::LPS_PH_DATA;
							else
							begin
								s_d.exp_code = s_q.exp_code + 16'h0001;
								if (s_d.page_rem == 16'h0000)
									s_d.ph = lps_pkg::LPS_PH_PAGE;
							end
						end
					end
					lps_pkg::LPS_PH_DATA:
					begin
						s_d.pos = 2'h0;
						s_d.page_rem = s_q.page_rem - 16'h0001;
						s_d.prm_rem = s_q.prm_rem - 8'h01;
						// list parameters bypass the page-control gate
						if ((s_q.page == lps_pkg::LPS_PG_START_STOP
							|| s_q.page == lps_pkg::LPS_PG_APP_CLIENT)
							&& (s_q.pc != lps_pkg::LPS_PC_DEF || s_q.fl == lps_pkg::LPS_FL_ASCII
							|| s_q.fl == lps_pkg::LPS_FL_BINARY))
						begin
							s_d.wr_valid = 1'b1;
							s_d.wr = '{s_q.page, s_q.exp_code, dout_data_i};
						end
						if (s_q.prm_rem == 8'h01)
						begin
							s_d.exp_code = s_q.exp_code + 16'h0001;
							s_d.ph = (s_q.page_rem == 16'h0001) ? lps_pkg::LPS_PH_PAGE
								: lps_pkg::LPS_PH_PRM;
						end
					end
					default:
						err = 1'b1;
				endcase
				// list must end exactly on a page boundary
				if (!err && s_d.cnt == s_q.len)
					err = !(s_d.ph == lps_pkg::LPS_PH_PAGE && s_d.pos == 2'h0);
				if (err)
				begin
					s_d.sts = '{1'b1, lps_pkg::LPS_KEY_ILLEGAL, lps_pkg::LPS_ASC_PLIST};
					s_d.dout_rdy = 1'b0;
					s_d.st = lps_pkg::LPS_ST_END;
				end
				else if (s_d.cnt == s_q.len)
				begin
					s_d.dout_rdy = 1'b0;
					s_d.st = lps_pkg::LPS_ST_END;
					s_d.ua = s_d.ua | others;
					s_d.save = s_q.sp;
				end
			end
			lps_pkg::LPS_ST_SEND:
			if (src_valid_i && s_q.src_rdy)
			begin
				s_d.din_valid = 1'b1;
				s_d.din_data = src_data_i;
				s_d.cnt = s_q.cnt + 16'h0001;
				if (s_d.cnt == s_q.len || src_last_i)
				begin
					s_d.src_rdy = 1'b0;
					s_d.st = lps_pkg::LPS_ST_END;
				end
			end
			lps_pkg::LPS_ST_END:
			begin
				s_d.done = 1'b1;
				s_d.cdb_rdy = 1'b1;
				s_d.st = lps_pkg::LPS_ST_IDLE;
			end
			default:
				s_d.st = lps_pkg::LPS_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_q <= '0;
			s_q.st <= lps_pkg::LPS_ST_IDLE;
			s_q.ph <= lps_pkg::LPS_PH_PAGE;
			s_q.cdb_rdy <= 1'b1;
			s_q.port <= lps_pkg::LPS_PORT_RST;
		end
		else
			s_q <= s_d;
	end

	assign cdb_ready_o = s_q.cdb_rdy;
	assign done_o = s_q.done;
	assign sts_o = s_q.sts;
	assign dout_ready_o = s_q.dout_rdy;
	assign log_page_o = s_q.page;
	assign log_pc_o = s_q.pc;
	assign param_ptr_o = s_q.ptr;
	assign src_ready_o = s_q.src_rdy;
	assign din_valid_o = s_q.din_valid;
	assign din_data_o = s_q.din_data;
	assign wr_valid_o = s_q.wr_valid;
	assign wr_o = s_q.wr;
	assign save_o = s_q.save;
	assign clr_valid_o = s_q.clr_valid;
	assign clr_mask_o = s_q.clr_mask;
	assign clr_cur_o = s_q.clr_cur;
	assign clr_def_o = s_q.clr_def;
	assign clr_port_o = s_q.port;
	assign ua_o = s_q.ua;
	assign wb_dat_o = s_q.dat;
	assign wb_ack_o = s_q.ack;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic cmd_take;
	assign cmd_take = cdb_valid_i && s_q.cdb_rdy && s_q.st == lps_pkg::LPS_ST_IDLE;

	property p_select_taken;
		cmd_take && cdb_i[0] == lps_pkg::LPS_OP_SELECT
		|=> !s_q.cdb_rdy ##1 (s_q.cdb_rdy == (s_q.st == lps_pkg::LPS_ST_IDLE));
	endproperty
	a_select_taken: assert property (p_select_taken) else $error("select not handled");

	property p_save_zero;
		cmd_take && cdb_i[0] == lps_pkg::LPS_OP_SELECT && cdb_i[8] != 8'h00 && cdb_i[7] == 8'h00
			&& !cdb_i[1][0] |=> s_q.sts.check && s_q.sts.asc == lps_pkg::LPS_ASC_CDB;
	endproperty
	a_save_zero: assert property (p_save_zero) else $error("length without save accepted");

	property p_def_len;
		cmd_take && cdb_i[0] == lps_pkg::LPS_OP_SELECT && cdb_i[2][7:6] == 2'h3
			&& cdb_i[8] != 8'h00 |=> s_q.st == lps_pkg::LPS_ST_END && s_q.sts.check;
	endproperty
	a_def_len: assert property (p_def_len) else $error("default page with length accepted");

	property p_long_len;
		cmd_take && cdb_i[0] == lps_pkg::LPS_OP_SELECT && cdb_i[7] != 8'h00
		|=> s_q.sts.check ##1 s_q.done;
	endproperty
	a_long_len: assert property (p_long_len) else $error("long list length accepted");

	property p_pointer;
		cmd_take && cdb_i[0] == lps_pkg::LPS_OP_SENSE && cdb_i[1][1]
		|=> s_q.sts.asc == lps_pkg::LPS_ASC_CDB && !s_q.src_rdy;
	endproperty
	a_pointer: assert property (p_pointer) else $error("pointer bit accepted");

	property p_zero_alloc;
		cmd_take && cdb_i[0] == lps_pkg::LPS_OP_SENSE && cdb_i[8] == 8'h00 && cdb_i[7] == 8'h00
		|=> !s_q.din_valid[*2];
	endproperty
	a_zero_alloc: assert property (p_zero_alloc) else $error("bytes sent with zero allocation");

	property p_store_pages;
		s_q.wr_valid |-> s_q.wr.page == lps_pkg::LPS_PG_START_STOP
			|| s_q.wr.page == lps_pkg::LPS_PG_APP_CLIENT;
	endproperty
	a_store_pages: assert property (p_store_pages) else $error("write to other page");

	property p_ua_others;
		s_q.clr_valid && (s_q.clr_cur || s_q.clr_def) |-> (&(s_q.ua | (8'h01 << s_q.iid)));
	endproperty
	a_ua_others: assert property (p_ua_others) else $error("unit attention missing");

	property p_default_reset;
		cmd_take && cdb_i[0] == lps_pkg::LPS_OP_SELECT && cdb_i[2][7:6] == 2'h3
			&& cdb_i[8] == 8'h00 && cdb_i[7] == 8'h00 && s_q.sts.check == 1'b0
		|=> s_q.clr_valid |-> s_q.clr_def;
	endproperty
	a_default_reset: assert property (p_default_reset) else $error("default not reset");
endmodule

`default_nettype wire

// >>> bench/lps_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module lps_src_model #(
	parameter int NBYTES = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// request from the block, and the pacing switch from the bench
	input wire logic src_ready_i,
	input wire logic [5:0] log_page_i,
	input wire logic slow_i,
	// log bytes
	output logic src_valid_o,
	output logic [7:0] src_data_o,
	output logic src_last_o
);
	logic [3:0] idx_q;
	logic [3:0] nx;
	logic v;
	assign nx = idx_q + {3'h0, src_valid_o};
	assign v = (slow_i ? !src_valid_o : 1'b1) && (nx < 4'(NBYTES));
	// data line toggles whenever no byte is offered, except in reset where it loads 8'h5a
	always @(posedge clk_i)
	begin
		if (rst_i || !src_ready_i)
		begin
			idx_q <= 4'h0;
			src_valid_o <= 1'b0;
			src_last_o <= 1'b0;
			src_data_o <= rst_i ? 8'h5a : ~src_data_o;
		end
		else
		begin
			idx_q <= nx;
			src_valid_o <= v;
			src_data_o <= v ? {log_page_i[3:0], nx} : ~src_data_o;
			src_last_o <= v && (nx == 4'(NBYTES - 1));
		end
	end
endmodule
`default_nettype wire

// >>> bench/lps_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lps_top_tb;
	logic clk_i, rst_i, cdb_valid_i, dout_valid_i, src_valid_i, src_last_i, slow;
	logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cdb_ready_o, done_o, dout_ready_o;
	logic src_ready_o, din_valid_o, wr_valid_o, save_o, clr_valid_o, clr_cur_o, clr_def_o;
	logic cur_q, def_q;
	lps_pkg::lps_cdb_t cdb_i;
	lps_pkg::lps_sts_t sts_o, ok, bad;
	lps_pkg::lps_wr_t wr_o, wr_q;
	logic [2:0] cdb_iid_i;
	logic [5:0] log_page_o;
	logic [1:0] log_pc_o;
	logic [15:0] param_ptr_o;
	lps_pkg::lps_cdb_t cmd;
	logic [7:0] dout_data_i, src_data_i, din_data_o, clr_mask_o, ua_o, mask_q;
	logic [3:0] clr_port_o, wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [31:0] t;
	logic [7:0] lst [24];
	logic [7:0] din_q [8];
	int errors, comparisons, n_wr, n_din, n_save, n_clr, i;

	lps_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cdb_valid_i(cdb_valid_i), .cdb_i(cdb_i),
		.cdb_iid_i(cdb_iid_i), .cdb_ready_o(cdb_ready_o), .done_o(done_o), .sts_o(sts_o),
		.dout_valid_i(dout_valid_i), .dout_data_i(dout_data_i), .dout_ready_o(dout_ready_o),
		.log_page_o(log_page_o), .log_pc_o(log_pc_o), .param_ptr_o(param_ptr_o),
		.src_valid_i(src_valid_i),
		.src_data_i(src_data_i), .src_last_i(src_last_i), .src_ready_o(src_ready_o),
		.din_valid_o(din_valid_o), .din_data_o(din_data_o), .wr_valid_o(wr_valid_o),
		.wr_o(wr_o), .save_o(save_o), .clr_valid_o(clr_valid_o), .clr_mask_o(clr_mask_o),
		.clr_cur_o(clr_cur_o), .clr_def_o(clr_def_o), .clr_port_o(clr_port_o), .ua_o(ua_o),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

	lps_src_model #(.NBYTES(4)) u_src (.clk_i(clk_i), .rst_i(rst_i),
		.src_ready_i(src_ready_o), .log_page_i(log_page_o), .slow_i(slow),
		.src_valid_o(src_valid_i), .src_data_o(src_data_i), .src_last_o(src_last_i));

	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// pulse monitor
	always @(posedge clk_i)
	begin
		if (wr_valid_o === 1'b1)
		begin
			n_wr++;
			wr_q = wr_o;
		end
		if (din_valid_o === 1'b1)
		begin
			if (n_din < 8)
				din_q[n_din] = din_data_o;
			n_din++;
		end
		if (save_o === 1'b1)
			n_save++;
		if (clr_valid_o === 1'b1)
		begin
			n_clr++;
			mask_q = clr_mask_o;
			cur_q = clr_cur_o;
			def_q = clr_def_o;
		end
	end

	task automatic final_report();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic tmo();
		errors++;
		$display("Error %0t: wait timed out", $time);
		final_report();
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_sts(input lps_pkg::lps_sts_t e);
		comparisons++;
		if (sts_o !== e)
		begin
			errors++;
			$display("Error %0t: status %h expected %h", $time, sts_o, e);
		end
	endtask

	task automatic wb_xfer(input logic we, input logic [3:0] a, input logic [31:0] d);
		int k;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		for (k = 0; k < 20; k++)
		begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1)
				break;
		end
		rd = wb_dat_o;
		if (k == 20)
			tmo();
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wb_rd(input logic [3:0] a, input logic [31:0] e);
		wb_xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	function automatic lps_pkg::lps_cdb_t mk(input logic [7:0] op, b1, b2, input logic [15:0] len);
		mk = '0;
		mk[0] = op;
		mk[1] = b1;
		mk[2] = b2;
		mk[7] = len[15:8];
		mk[8] = len[7:0];
	endfunction

	// issue one command, feed n list bytes, wait for completion
	task automatic run(input lps_pkg::lps_cdb_t c, input logic [2:0] iid, input int n);
		int k;
		int idx;
		n_wr = 0;
		n_din = 0;
		n_save = 0;
		n_clr = 0;
		cur_q = 1'b0;
		def_q = 1'b0;
		idx = 0;
		cdb_i <= c;
		cdb_iid_i <= iid;
		cdb_valid_i <= 1'b1;
		for (k = 0; k < 50; k++)
		begin
			@(posedge clk_i);
			if (cdb_ready_o === 1'b1)
				break;
		end
		if (k == 50)
			tmo();
		cdb_valid_i <= 1'b0;
		dout_valid_i <= (n > 0);
		dout_data_i <= lst[0];
		for (k = 0; k < 300; k++)
		begin
			@(posedge clk_i);
			if (done_o === 1'b1)
				break;
			if (dout_valid_i && dout_ready_o === 1'b1)
			begin
				idx++;
				dout_valid_i <= (idx < n);
				dout_data_i <= lst[idx % 24];
			end
		end
		dout_valid_i <= 1'b0;
		if (k == 300)
			tmo();
	endtask

	initial
	begin
		rst_i = 1'b1;
		cdb_valid_i = 1'b0;
		cdb_i = '0;
		cdb_iid_i = 3'h0;
		dout_valid_i = 1'b0;
		dout_data_i = 8'h0;
		slow = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		errors = 0;
		comparisons = 0;
		ok = '0;
		bad = {1'b1, 4'h5, 8'h24};
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(32'(ua_o), 32'h0);
		wb_rd(4'h0, 32'h0);
		wb_rd(4'h4, 32'h0);
		wb_rd(4'hc, 32'h0);
		wb_xfer(1'b1, 4'h8, 32'h3);
		wb_rd(4'h8, 32'h3);
		// select refusals: flags, control/page, list length
		for (i = 0; i < 6; i++)
		begin
			t = i == 0 ? 32'h0140_0100 : i == 1 ? 32'h0340_0001 : i == 2 ? 32'h0040_0001 :
				i == 3 ? 32'h01c0_0001 : i == 4 ? 32'h0142_0001 : 32'h0041_0000;
			run(mk(8'h4c, t[31:24], t[23:16], t[15:0]), 3'h0, 0);
			chk_sts(bad);
			chk(n_clr + n_wr, 0);
		end
		wb_rd(4'h0, 32'h0000_1524);
		chk(32'(ua_o), 32'h0);
		run(mk(8'h4c, 8'h03, 8'h40, 16'h0), 3'h2, 0);
		chk_sts(ok);
		chk(32'({4'(n_clr), mask_q, cur_q, def_q}), 32'h7fe);
		chk(32'({clr_port_o, ua_o}), 32'h3fb);
		chk(n_save, 1);
		wb_xfer(1'b1, 4'h4, 32'hff);
		wb_rd(4'h4, 32'h0);
		for (i = 0; i < 3; i++)
		begin
			t = i == 0 ? 32'h0201 : i == 1 ? 32'h1820 : 32'h3780;
			run(mk(8'h4c, 8'h00, 8'hc0 | t[15:8], 16'h0), 3'h0, 0);
			chk(32'({mask_q, cur_q, def_q}), {22'h0, t[7:0], 2'b01});
			chk(32'({ua_o, 4'(n_save)}), 32'hfe0);
		end
		wb_xfer(1'b1, 4'h4, 32'hff);
		run(mk(8'h4c, 8'h00, 8'h40, 16'h0), 3'h0, 0);
		chk(32'({cur_q, def_q, ua_o}), 32'h0);
		// two ascending pages, only the start-stop page is stored
		lst = '{8'h0e, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01, 8'ha5,
			8'h10, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01, 8'h5a,
			8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
		run(mk(8'h4c, 8'h01, 8'h40, 16'd18), 3'h1, 18);
		chk_sts(ok);
		chk(32'({n_wr, wr_q}), {2'h1, 6'h0e, 16'h0, 8'ha5});
		chk(32'({ua_o, 4'(n_save)}), 32'hfd1);
		lst[0] = 8'h0f;
		lst[5] = 8'h01;
		run(mk(8'h4c, 8'h01, 8'h40, 16'd9), 3'h1, 9);
		chk_sts({1'b1, 4'h5, 8'h26});
		chk(n_wr, 0);
		// sense refusals: pointer bit, control 00b and 10b, bad page
		for (i = 0; i < 4; i++)
		begin
			t = i == 0 ? 32'h0242 : i == 1 ? 32'h0002 : i == 2 ? 32'h0082 : 32'h0041;
			run(mk(8'h4d, t[15:8], t[7:0], 16'h8), 3'h0, 0);
			chk_sts(bad);
			chk(n_din, 0);
		end
		run(mk(8'h4d, 8'h01, 8'h42, 16'h0), 3'h0, 0);
		chk_sts(ok);
		chk(32'({4'(n_din), 4'(n_save)}), 32'h01);
		run(mk(8'h4d, 8'h00, 8'h42, 16'h2), 3'h0, 0);
		chk(32'({4'(n_din), din_q[0], din_q[1], 4'(n_save)}), 32'h220210);
		slow = 1'b1;
		cmd = mk(8'h4d, 8'h00, 8'hc3, 16'h8);
		cmd[5] = 8'h12;
		cmd[6] = 8'h34;
		run(cmd, 3'h0, 0);
		chk_sts(ok);
		chk(32'({log_pc_o, param_ptr_o}), 32'h31234);
		chk(32'({4'(n_din), din_q[0], din_q[3]}), 32'h43033);
		final_report();
	end
endmodule
`default_nettype wire
